//--- common/lfs_consts.vh
// Constants for the LED function select block.
// Notes on behaviour
// RQ1 - Stretch bit 7 lengthens each enabled event.
// RQ2 - Bit 6 reserved, reads zero, write zero.
// RQ3 - Bit 5 limits receive to address-matched frames.
// RQ4 - Bit 4 lets transmit activity drive LED.
// RQ5 - Bit 3 shows correct receive polarity.
// RQ6 - Bit 2 lets receive activity drive LED.
// RQ7 - Bit 1 lets transmitter jabber drive LED.
// RQ8 - Bit 0 lets collisions drive LED.
// RQ9 - LED is OR of enabled sources.
// RQ10 - Bit 15 reads unstretched OR, read only.
// RQ11 - Stretch holds fixed cycles, restarts per event.
`ifndef LFS_CONSTS_VH
`define LFS_CONSTS_VH
`define LFS_CTRL_ADDR     4'h0
`define LFS_SRC_ADDR      4'h4
`define LFS_BIT_RAW       15
`define LFS_BIT_STRETCH   7
`define LFS_BIT_RESERVED  6
`define LFS_BIT_RXMATCH   5
`define LFS_BIT_TX        4
`define LFS_BIT_POL       3
`define LFS_BIT_RX        2
`define LFS_BIT_JAB       1
`define LFS_BIT_COL       0
`define LFS_CTRL_RESET    8'h90
`define LFS_CTRL_WMASK    8'hbf
`define LFS_STRETCH_NS    50000000
`define LFS_CLK_NS        25
`define LFS_STRETCH_CYC   (`LFS_STRETCH_NS / `LFS_CLK_NS)
`endif

//--- core/lfs_led_select.v
// LED function select with a classic Wishbone register slave.
`timescale 1ns/100ps
`include "lfs_consts.vh"
module lfs_led_select #(
    parameter STRETCH_CYC = `LFS_STRETCH_CYC
) (
    input  wire        mclk_in,
    input  wire        rst_n_in,
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [3:0]  wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    input  wire        tx_active_in,
    input  wire        rx_active_in,
    input  wire        rx_addr_match_in,
    input  wire        polarity_ok_in,
    input  wire        jabber_in,
    input  wire        collision_in,
    output reg         led_out
);
    ////////////////////////////////////////////////////////////////////////
    // Register map constants.
    localparam [3:0]        CTRL_ADDR = `LFS_CTRL_ADDR;
    localparam [3:0]        SRC_ADDR  = `LFS_SRC_ADDR;
    localparam [7:0]        CTRL_RST  = `LFS_CTRL_RESET;
    localparam [7:0]        CTRL_MASK = `LFS_CTRL_WMASK;
    localparam              HOLD_W    = 21;
    localparam [HOLD_W-1:0] HOLD_VAL  = STRETCH_CYC[HOLD_W-1:0];

    ////////////////////////////////////////////////////////////////////////
    // Registers, next values and internal nets.
    reg  [7:0]  ctrl_reg;
    reg  [7:0]  ctrl_next;
    reg         ack_next;
    reg  [31:0] rdata_next;
    reg         led_next;
    wire        req;
    wire        wr_strobe;
    wire        rd_strobe;
    wire        ctrl_hit;
    wire        src_hit;
    wire [7:0]  wr_byte;
    wire        stretch_enable;
    wire        rx_match_only;
    wire        tx_activity_enable;
    wire        polarity_ok_enable;
    wire        rx_activity_enable;
    wire        jabber_enable;
    wire        collision_enable;
    wire        rx_src;
    wire        tx_term;
    wire        pol_term;
    wire        rx_term;
    wire        jab_term;
    wire        col_term;
    wire        led_raw_state;
    wire        stretched;
    wire [5:0]  src_vec;
    wire [31:0] ctrl_rd_word;
    wire [31:0] src_rd_word;

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.
    // Tells whether a bus address selects the given register.
    function addr_hit;
        input [3:0] addr;
        input [3:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Lets one source through when its enable bit is set.
    function gate_src;
        input enable;
        input source;
        begin
            gate_src = enable & source;
        end
    endfunction

    // Builds the control register read word.
    function [31:0] ctrl_word;
        input       raw;
        input [7:0] ctrl;
        begin
            ctrl_word = {16'h0000, raw, 7'h00, ctrl & CTRL_MASK};
        end
    endfunction

    // Builds the source status read word.
    function [31:0] src_word;
        input [5:0] sources;
        begin
            src_word = {{26{1'b0}}, sources};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Control field decode.
    assign stretch_enable     = ctrl_reg[`LFS_BIT_STRETCH];
    assign rx_match_only      = ctrl_reg[`LFS_BIT_RXMATCH];
    assign tx_activity_enable = ctrl_reg[`LFS_BIT_TX];
    assign polarity_ok_enable = ctrl_reg[`LFS_BIT_POL];
    assign rx_activity_enable = ctrl_reg[`LFS_BIT_RX];
    assign jabber_enable      = ctrl_reg[`LFS_BIT_JAB];
    assign collision_enable   = ctrl_reg[`LFS_BIT_COL];

    ////////////////////////////////////////////////////////////////////////
    // Source selection and combination.
    assign rx_src        = rx_active_in & (~rx_match_only | rx_addr_match_in); // [RQ3]
    assign tx_term       = gate_src(tx_activity_enable, tx_active_in);         // [RQ4]
    assign pol_term      = gate_src(polarity_ok_enable, polarity_ok_in);       // [RQ5]
    assign rx_term       = gate_src(rx_activity_enable, rx_src);               // [RQ6]
    assign jab_term      = gate_src(jabber_enable, jabber_in);                 // [RQ7]
    assign col_term      = gate_src(collision_enable, collision_in);           // [RQ8]
    assign led_raw_state = tx_term | pol_term | rx_term | jab_term | col_term; // [RQ9]
    assign src_vec       = {collision_in, jabber_in, rx_active_in,
                            polarity_ok_in, tx_active_in, rx_addr_match_in};

    ////////////////////////////////////////////////////////////////////////
    // Pulse stretcher and LED drive.
    lfs_stretch #(
        .WIDTH (HOLD_W),
        .HOLD  (HOLD_VAL)
    ) u_stretch (
        .mclk_in   (mclk_in),
        .rst_n_in  (rst_n_in),
        .enable_in (stretch_enable),
        .event_in  (led_raw_state),
        .led_out   (stretched)
    );

    // The LED shows the stretched indication only while stretching is on.
    always @* begin
        if (stretch_enable) begin
            led_next = stretched; // [RQ1]
        end else begin
            led_next = led_raw_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: a request is acked one cycle after it is taken.
    assign req          = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    assign wr_strobe    = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in;
    assign rd_strobe    = req & ~wb_we_in;
    assign ctrl_hit     = addr_hit(wb_adr_in, CTRL_ADDR);
    assign src_hit      = addr_hit(wb_adr_in, SRC_ADDR);
    assign wr_byte      = wb_dat_in[7:0];
    assign ctrl_rd_word = ctrl_word(led_raw_state, ctrl_reg); // [RQ10]
    assign src_rd_word  = src_word(src_vec);

    // Writes land on the edge where the master sees ack, with the request still whole.
    always @* begin
        ctrl_next = ctrl_reg;
        if (wr_strobe && ctrl_hit && wb_sel_in[0]) begin
            ctrl_next = wr_byte & CTRL_MASK; // [RQ2]
        end
    end

    // Ack is a single pulse, since a standing ack blocks a new request.
    always @* begin
        ack_next = req;
    end

    // Read data is loaded when a read is taken and then holds.
    always @* begin
        rdata_next = wb_dat_out;
        if (rd_strobe) begin
            if (ctrl_hit) begin
                rdata_next = ctrl_rd_word;
            end else if (src_hit) begin
                rdata_next = src_rd_word;
            end else begin
                rdata_next = 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers.
    // Control register.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= CTRL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Bus acknowledge.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
        end else begin
            wb_ack_out <= ack_next;
        end
    end

    // Bus read data.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_dat_out <= rdata_next;
        end
    end

    // LED drive.
    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_out <= 1'b0;
        end else begin
            led_out <= led_next;
        end
    end
endmodule

//--- core/lfs_stretch.v
// Pulse stretcher that holds its output for a fixed cycle count.
`timescale 1ns/100ps
module lfs_stretch #(
    parameter WIDTH = 21,
    parameter [WIDTH-1:0] HOLD = 21'd2000000
) (
    input  wire mclk_in,
    input  wire rst_n_in,
    input  wire enable_in,
    input  wire event_in,
    output wire led_out
);
    reg [WIDTH-1:0] count_reg;
    reg [WIDTH-1:0] count_next;

    always @* begin
        count_next = count_reg;
        if (!enable_in) begin
            count_next = {WIDTH{1'b0}};
        end else if (event_in) begin
            count_next = HOLD; // [RQ11]
        end else if (count_reg != {WIDTH{1'b0}}) begin
            count_next = count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_reg <= {WIDTH{1'b0}};
        end else begin
            count_reg <= count_next;
        end
    end

    // Event itself lights the LED at once; the count extends it.
    assign led_out = event_in | (enable_in & (count_reg != {WIDTH{1'b0}})); // [RQ1]
endmodule

//--- testbench/lfs_led_lamp.sv
// Model of the status lamp that counts lit clock cycles.
`timescale 1ns/100ps
module lfs_led_lamp (
    input  wire logic       mclk_in,
    input  wire logic       led_in,
    input  wire logic       clr_in,
    output logic      [7:0] lit_out
);
    always @(posedge mclk_in) begin
        lit_out <= clr_in ? 8'h00 : lit_out + {7'h00, led_in};
    end
endmodule

//--- testbench/lfs_led_select_properties.sv
// Checker of the LED select block ports.
`timescale 1ns/100ps
module lfs_sel_props (
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic        wb_ack_out,
    input wire logic        led_out,
    input wire logic        tx_active_in,
    input wire logic        rx_active_in,
    input wire logic        polarity_ok_in,
    input wire logic        jabber_in,
    input wire logic        collision_in,
    input wire logic [3:0]  wb_adr_in,
    input wire logic [31:0] wb_dat_out
);
    wire rd = wb_ack_out & !wb_we_in & wb_adr_in == 4'h0;
    wire any = tx_active_in | rx_active_in | polarity_ok_in | jabber_in | collision_in;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    chk_ack_once: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    chk_ack_soon: assert property (wb_cyc_in & wb_stb_in & !wb_ack_out |=> wb_ack_out) else $error("no ack");
    chk_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in & wb_stb_in)) else $error("stray ack");
    chk_data_hold: assert property (!$stable(wb_dat_out) |-> wb_ack_out) else $error("data moved");
    chk_rsv_zero: assert property (rd |-> !wb_dat_out[6]) else $error("bit 6 set");
    chk_raw_cause: assert property (rd & wb_dat_out[15] |-> $past(any)) else $error("raw bit");
    chk_led_cause: assert property ($rose(led_out) |-> $past(any)) else $error("led rose");
    chk_led_idle: assert property (!led_out & !any |=> !led_out) else $error("led lit");
    cover property (wb_ack_out & wb_we_in);
    cover property (rd & wb_dat_out[15]);
    cover property ($fell(led_out));
endmodule
bind lfs_led_select lfs_sel_props u_props (
    .mclk_in        (mclk_in),
    .rst_n_in       (rst_n_in),
    .wb_cyc_in      (wb_cyc_in),
    .wb_stb_in      (wb_stb_in),
    .wb_we_in       (wb_we_in),
    .wb_ack_out     (wb_ack_out),
    .led_out        (led_out),
    .tx_active_in   (tx_active_in),
    .rx_active_in   (rx_active_in),
    .polarity_ok_in (polarity_ok_in),
    .jabber_in      (jabber_in),
    .collision_in   (collision_in),
    .wb_adr_in      (wb_adr_in),
    .wb_dat_out     (wb_dat_out)
);

//--- testbench/lfs_led_select_tb.sv
// Bench for the LED select block.
`timescale 1ns/100ps
module lfs_led_select_tb;
    logic        mclk_in = 1'b0, rst_n_in = 1'b0, wb_cyc_in = 1'b0, wb_we_in = 1'b0, clr = 1'b1;
    logic [3:0]  wb_adr_in = 4'h0, wb_sel_in = 4'hf;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, d;
    logic [5:0]  s = 6'h00;
    logic [7:0]  c, lit;
    wire         wb_stb_in = wb_cyc_in;
    wire         wb_ack_out, led_out, tx_active_in, rx_active_in, rx_addr_match_in;
    wire         polarity_ok_in, jabber_in, collision_in;
    int          bad_count = 0, checks = 0, n = 0, seed = 20643;
    assign {collision_in, jabber_in, rx_active_in, polarity_ok_in, tx_active_in, rx_addr_match_in} = s;
    lfs_led_select #(.STRETCH_CYC(8)) dut (.*);
    lfs_led_lamp lamp (.mclk_in(mclk_in), .led_in(led_out), .clr_in(clr), .lit_out(lit));
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) if (++n > 9000) begin
        bad_count++;
        report_and_stop();
    end
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        {wb_cyc_in, wb_we_in, wb_adr_in, wb_dat_in} <= {1'b1, w, a, v};
        do @(posedge mclk_in); while (wb_ack_out !== 1'b1);
        d = wb_dat_out;
        wb_cyc_in <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic raw(input logic [7:0] k, input logic [5:0] x);
        return x[1] & k[4] | x[3] & k[2] & (!k[5] | x[0]) | x[2] & k[3] | x[4] & k[1] | x[5] & k[0];
    endfunction
    task automatic report_and_stop();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk(d, 32'h90);
        bus(1'b1, 4'h0, 32'hff);
        bus(1'b0, 4'h0, 32'h0);
        chk(d, 32'hbf);
        repeat (60) begin
            c = 8'($random(seed)) & 8'h3f;
            s <= 6'($random(seed));
            bus(1'b1, 4'h0, {24'h0, c});
            repeat (2) @(posedge mclk_in);
            chk(led_out, raw(c, s));
            bus(1'b0, 4'h0, 32'h0);
            chk(d, {raw(c, s), 7'h0, c & 8'hbf});
            bus(1'b0, 4'h4, 32'h0);
            chk(d, {26'h0, s});
        end
        s <= 6'h00;
        bus(1'b1, 4'h0, 32'h3f);
        rst_n_in <= 1'b0;
        repeat (6) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk(d, 32'h90);
        bus(1'b1, 4'h0, 32'h90);
        wb_sel_in <= 4'he;
        bus(1'b1, 4'h0, 32'h00);
        wb_sel_in <= 4'hf;
        bus(1'b0, 4'h0, 32'h0);
        chk(d, 32'h90);
        bus(1'b0, 4'h8, 32'h0);
        chk(d, 32'h0);
        repeat (10) @(posedge mclk_in);
        clr <= 1'b0;
        s <= 6'h02;
        @(posedge mclk_in);
        s <= 6'h00;
        repeat (12) @(posedge mclk_in);
        chk(lit, 8'h09);
        report_and_stop();
    end
endmodule
